// ==== vic_defs.svh ====
// Register indices, field positions, reset values and vectors of the interrupt controller
`ifndef VIC_DEFS_SVH
`define VIC_DEFS_SVH

// Register indices; byte address is four times the index
`define VIC_IDX_TMR0_STAT 6'h05
`define VIC_IDX_CPU_STAT 6'h06
`define VIC_IDX_IRQ_STAT 6'h07
`define VIC_IDX_PERI_FLAG 6'h16
`define VIC_IDX_PERI_EN 6'h17
`define VIC_IDX_EVT 6'h20
`define VIC_IDX_MASK 6'h21

// Field positions
`define VIC_CPU_GD_BIT 4
`define VIC_T0_PIN_EDGE_BIT 7
`define VIC_T0_CKPIN_EDGE_BIT 6
`define VIC_IS_PINE_BIT 0
`define VIC_IS_OVF_EN_BIT 1
`define VIC_IS_CKIE_BIT 2
`define VIC_IS_GRP_EN_BIT 3
`define VIC_IS_PINF_BIT 4
`define VIC_IS_OVF_FLAG_BIT 5
`define VIC_IS_CKIF_BIT 6
`define VIC_IS_SUM_BIT 7

// Reset values
`define VIC_RST_GD 1'b1
`define VIC_RST_PERI_EN 8'h00
`define VIC_RST_BYTE 8'h00

// Fixed vectors, highest priority first
`define VIC_VEC_PIN 16'h0008
`define VIC_VEC_T0 16'h0010
`define VIC_VEC_CK 16'h0018
`define VIC_VEC_PERI 16'h0020

`endif

// ==== vic_pkg.sv ====
// Types shared by the interrupt controller modules
package vic_pkg;
  typedef enum logic [0:0] {
    VIC_ST_IDLE = 1'b0,
    VIC_ST_VEC = 1'b1
  } vic_state_t;
  typedef logic [15:0] vic_addr_t;
endpackage : vic_pkg

// ==== vic_pin_edge.sv ====
// Pin synchroniser and selectable edge detector
`timescale 1ns/100ps
module vic_pin_edge (
  input wire logic clk,
  input wire logic reset,
  input wire logic pin,
  input wire logic rising_sel,
  output logic edge_pulse
);
  logic sync1_q;
  logic sync2_q;
  logic prev_q;

  // Two stages before use; first stage feeds only the second
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // Rising when selected, falling otherwise
  assign edge_pulse = rising_sel ? (sync2_q & ~prev_q) : (~sync2_q & prev_q);
endmodule : vic_pin_edge

// ==== vic_prio.sv ====
// Fixed priority resolver over the four vectors
`timescale 1ns/100ps
`include "vic_defs.svh"
module vic_prio
  import vic_pkg::*;
(
  input wire logic [3:0] pending,
  output logic any,
  output vic_addr_t vec_addr
);
  // Lowest index wins; pin interrupt first, peripherals last
  assign any = |pending;
  assign vec_addr = pending[0] ? `VIC_VEC_PIN :
                    pending[1] ? `VIC_VEC_T0 :
                    pending[2] ? `VIC_VEC_CK :
                    `VIC_VEC_PERI;
endmodule : vic_prio

// ==== vic_core.sv ====
// Vectored interrupt controller with Avalon-MM register slave
//
// How it works
// - Global disable bit blocks every interrupt.
// - Reset sets global disable.
// - Each core source has its own enable.
// - Group or own enable zero blocks peripheral.
// - Return clears disable, loads PC from stack.
// - Taking interrupt sets disable, pushes, vectors.
// - Pin 0008h, overflow 0010h, clock pin 0018h.
// - Peripherals 0020h lowest; highest priority first.
// - Flags set regardless of enables.
// - Pin interrupt edge selectable rising/falling.
// - Valid pin edge sets pin flag.
// - Clearing pin enable masks pin interrupt.
// - Enabled pin interrupt wakes from sleep.
// - Eight peripheral enables, reset to zero.
// - Summary is OR of flag AND enable.
`timescale 1ns/100ps
`include "vic_defs.svh"
module vic_core
  import vic_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ext_irq_pin,
  input wire logic timer0_clock_pin,
  input wire logic timer0_overflow,
  input wire logic [7:0] periph_events,
  input wire logic instr_boundary,
  input wire logic return_from_irq_instr,
  input wire vic_addr_t return_pc,
  input wire vic_addr_t stack_top,
  output logic vector_valid,
  output vic_addr_t vector_addr,
  output logic stack_push,
  output vic_addr_t stack_push_addr,
  output logic stack_pop,
  output logic pc_load,
  output vic_addr_t pc_load_addr,
  output logic wake,
  output logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic ack_q;
  logic [31:0] rdata_q;
  logic global_irq_disable_q;
  logic [3:0] core_en_q;
  logic pin_irq_flag_q;
  logic timer0_overflow_flag_q;
  logic timer0_clkpin_irq_flag_q;
  logic [1:0] edge_sel_q;
  logic [7:0] peripheral_irq_enable_1_q;
  logic [7:0] peripheral_flag_regs_q;
  logic [1:0] evt_q;
  logic [1:0] mask_q;
  vic_state_t state_q;
  logic vec_valid_q;
  vic_addr_t vec_addr_q;
  logic push_q;
  vic_addr_t push_addr_q;
  logic pop_q;
  logic pc_load_q;
  vic_addr_t pc_addr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode
  wire [5:0] idx = avs_address[7:2];
  wire req = avs_read | avs_write;
  wire wr_fire = avs_write & ack_q & avs_byteenable[0];
  wire [7:0] wbyte = avs_writedata[7:0];
  wire wr_tmr0_stat = wr_fire & (idx == `VIC_IDX_TMR0_STAT);
  wire wr_cpu_stat = wr_fire & (idx == `VIC_IDX_CPU_STAT);
  wire wr_irq_stat = wr_fire & (idx == `VIC_IDX_IRQ_STAT);
  wire wr_peri_flag = wr_fire & (idx == `VIC_IDX_PERI_FLAG);
  wire wr_peri_en = wr_fire & (idx == `VIC_IDX_PERI_EN);
  wire wr_evt = wr_fire & (idx == `VIC_IDX_EVT);
  wire wr_mask = wr_fire & (idx == `VIC_IDX_MASK);

  // One wait cycle per access, so read data always comes from a flop
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Event sources
  wire pin_edge;
  wire clkpin_edge;

  vic_pin_edge u_pin_edge (
    .clk(clk),
    .reset(reset),
    .pin(ext_irq_pin),
    .rising_sel(edge_sel_q[1]),
    .edge_pulse(pin_edge)
  );

  vic_pin_edge u_clkpin_edge (
    .clk(clk),
    .reset(reset),
    .pin(timer0_clock_pin),
    .rising_sel(edge_sel_q[0]),
    .edge_pulse(clkpin_edge)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pending and priority
  wire peripheral_irq_summary = |(peripheral_flag_regs_q & peripheral_irq_enable_1_q);
  wire [3:0] pending;
  assign pending[0] = pin_irq_flag_q & core_en_q[`VIC_IS_PINE_BIT];
  assign pending[1] = timer0_overflow_flag_q & core_en_q[`VIC_IS_OVF_EN_BIT];
  assign pending[2] = timer0_clkpin_irq_flag_q & core_en_q[`VIC_IS_CKIE_BIT];
  assign pending[3] = peripheral_irq_summary & core_en_q[`VIC_IS_GRP_EN_BIT];
  wire any_pending;
  vic_addr_t sel_vec;

  vic_prio u_prio (
    .pending(pending),
    .any(any_pending),
    .vec_addr(sel_vec)
  );

  // Taken only between instructions and while not globally disabled
  wire take = (state_q == VIC_ST_IDLE) & instr_boundary & ~global_irq_disable_q
              & any_pending;
  wire do_return = return_from_irq_instr & ~take;

  // Sleep wake does not depend on the global disable
  assign wake = |pending;

  ////////////////////////////////////////////////////////////////////////////
  // Vectoring sequencer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= VIC_ST_IDLE;
    end else begin
      case (state_q)
        VIC_ST_IDLE: begin
          if (take) begin
            state_q <= VIC_ST_VEC;
          end
        end
        VIC_ST_VEC: begin
          state_q <= VIC_ST_IDLE;
        end
        default: begin
          state_q <= VIC_ST_IDLE;
        end
      endcase
    end
  end

  // Core-facing pulses, each one cycle after the decision
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      vec_valid_q <= 1'b0;
      vec_addr_q <= 16'h0000;
      push_q <= 1'b0;
      push_addr_q <= 16'h0000;
      pop_q <= 1'b0;
      pc_load_q <= 1'b0;
      pc_addr_q <= 16'h0000;
    end else begin
      vec_valid_q <= take;
      push_q <= take;
      pop_q <= do_return;
      pc_load_q <= take | do_return;
      if (take) begin
        vec_addr_q <= sel_vec;
        push_addr_q <= return_pc;
        pc_addr_q <= sel_vec;
      end else if (do_return) begin
        pc_addr_q <= stack_top;
      end
    end
  end

  assign vector_valid = vec_valid_q;
  assign vector_addr = vec_addr_q;
  assign stack_push = push_q;
  assign stack_push_addr = push_addr_q;
  assign stack_pop = pop_q;
  assign pc_load = pc_load_q;
  assign pc_load_addr = pc_addr_q;

  ////////////////////////////////////////////////////////////////////////////
  // Global disable: hardware take beats return, return beats software
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      global_irq_disable_q <= `VIC_RST_GD;
    end else if (take) begin
      global_irq_disable_q <= 1'b1;
    end else if (return_from_irq_instr) begin
      global_irq_disable_q <= 1'b0;
    end else if (wr_cpu_stat) begin
      global_irq_disable_q <= wbyte[`VIC_CPU_GD_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enables and edge selects
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      core_en_q <= 4'h0;
      edge_sel_q <= 2'b00;
      peripheral_irq_enable_1_q <= `VIC_RST_PERI_EN;
      mask_q <= 2'b00;
    end else begin
      if (wr_irq_stat) begin
        core_en_q <= wbyte[3:0];
      end
      if (wr_tmr0_stat) begin
        edge_sel_q <= {wbyte[`VIC_T0_PIN_EDGE_BIT], wbyte[`VIC_T0_CKPIN_EDGE_BIT]};
      end
      if (wr_peri_en) begin
        peripheral_irq_enable_1_q <= wbyte;
      end
      if (wr_mask) begin
        mask_q <= wbyte[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: set by events whatever the enables; a set beats a software write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_irq_flag_q <= 1'b0;
      timer0_overflow_flag_q <= 1'b0;
      timer0_clkpin_irq_flag_q <= 1'b0;
      peripheral_flag_regs_q <= `VIC_RST_BYTE;
    end else begin
      pin_irq_flag_q <= (wr_irq_stat ? wbyte[`VIC_IS_PINF_BIT] : pin_irq_flag_q)
                        | pin_edge;
      timer0_overflow_flag_q <= (wr_irq_stat ? wbyte[`VIC_IS_OVF_FLAG_BIT]
                                 : timer0_overflow_flag_q) | timer0_overflow;
      timer0_clkpin_irq_flag_q <= (wr_irq_stat ? wbyte[`VIC_IS_CKIF_BIT]
                                   : timer0_clkpin_irq_flag_q) | clkpin_edge;
      peripheral_flag_regs_q <= (wr_peri_flag ? wbyte : peripheral_flag_regs_q)
                                | periph_events;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Controller events: taken and returned, write one to clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      evt_q <= 2'b00;
    end else begin
      evt_q <= (evt_q & ~(wr_evt ? wbyte[1:0] : 2'b00)) | {do_return, take};
    end
  end

  assign irq = |(evt_q & mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Read data and handshake
  wire [7:0] cpu_stat_rd = {3'b000, global_irq_disable_q, 4'h0};
  wire [7:0] irq_stat_rd = {peripheral_irq_summary, timer0_clkpin_irq_flag_q,
                            timer0_overflow_flag_q, pin_irq_flag_q, core_en_q};
  // Unmapped indices read as zero and ignore writes
  wire [7:0] rd_byte = (idx == `VIC_IDX_TMR0_STAT) ? {edge_sel_q, 6'b00_0000} :
                       (idx == `VIC_IDX_CPU_STAT) ? cpu_stat_rd :
                       (idx == `VIC_IDX_IRQ_STAT) ? irq_stat_rd :
                       (idx == `VIC_IDX_PERI_FLAG) ? peripheral_flag_regs_q :
                       (idx == `VIC_IDX_PERI_EN) ? peripheral_irq_enable_1_q :
                       (idx == `VIC_IDX_EVT) ? {6'b00_0000, evt_q} :
                       (idx == `VIC_IDX_MASK) ? {6'b00_0000, mask_q} :
                       8'h00;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (avs_read & ~ack_q) begin
        rdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  gd_blocks_take_a: assert property (global_irq_disable_q |=> !vector_valid && !stack_push)
    else $error("interrupt taken while globally disabled");
  take_sets_gd_a: assert property (take |=> global_irq_disable_q && stack_push && vector_valid)
    else $error("take did not disable, push and vector");
  pin_vec_first_a: assert property (take && pending[0] |=> vector_addr == 16'h0008)
    else $error("pin interrupt not given top priority");
  peri_vec_last_a: assert property (take && pending == 4'b1000 |=> vector_addr == 16'h0020)
    else $error("peripheral vector wrong");
  return_clears_a: assert property (do_return |=> !global_irq_disable_q && pc_load
                                    && pc_load_addr == $past(stack_top))
    else $error("return did not clear disable or load stack top");
  pin_flag_set_a: assert property (pin_edge |=> pin_irq_flag_q)
    else $error("pin edge lost");
  peri_group_a: assert property (!core_en_q[3] && pending[2:0] == 3'b000
                                 |-> !any_pending && !wake)
    else $error("peripheral pending with group disabled");
  boundary_only_a: assert property (vector_valid |-> $past(instr_boundary))
    else $error("vectored off an instruction boundary");
  pin_wake_a: assert property (pin_irq_flag_q && core_en_q[0] |-> wake)
    else $error("enabled pin interrupt did not wake");
  flag_ignores_en_a: assert property (timer0_overflow |=> timer0_overflow_flag_q)
    else $error("overflow flag not set");
endmodule : vic_core

// ==== vic_cpu_model.sv ====
// Core model: instruction boundaries, return instruction and return stack
`timescale 1ns/100ps
module vic_cpu_model
  import vic_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic slow,
  input wire logic ret_req,
  input wire logic stack_push,
  input wire vic_addr_t stack_push_addr,
  input wire logic stack_pop,
  input wire logic pc_load,
  input wire vic_addr_t pc_load_addr,
  output logic instr_boundary,
  output logic return_from_irq_instr,
  output vic_addr_t return_pc,
  output vic_addr_t stack_top
);
  logic [1:0] ph_q;
  logic [1:0] sp_q;
  vic_addr_t pc_q;
  vic_addr_t stk_q [4];
  ////////////////////////////////////////////////////////////////////////////
  // Slow mode mimics multi-cycle instructions: a boundary every fourth cycle
  assign instr_boundary = ~slow | (ph_q == 2'd3);
  assign return_pc = pc_q;
  assign stack_top = stk_q[sp_q - 2'd1];
  // Stack and counter follow the push, pop and load strobes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ph_q <= 2'd0;
      sp_q <= 2'd0;
      pc_q <= 16'h0100;
      stk_q <= '{default: 16'h0000};
      return_from_irq_instr <= 1'b0;
    end else begin
      ph_q <= ph_q + 2'd1;
      return_from_irq_instr <= ret_req;
      if (pc_load) pc_q <= pc_load_addr;
      else if (instr_boundary) pc_q <= pc_q + 16'h0002;
      if (stack_push) begin
        stk_q[sp_q] <= stack_push_addr;
        sp_q <= sp_q + 2'd1;
      end else if (stack_pop) sp_q <= sp_q - 2'd1;
    end
  end
endmodule : vic_cpu_model

// ==== testbench.sv ====
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/100ps
module testbench
  import vic_pkg::*;
;
  logic clk = 1'b0, reset = 1'b1, rd = 1'b0, wr = 1'b0, pin = 1'b0, ckp = 1'b0;
  logic ovf = 1'b0, ret_req = 1'b0, slow = 1'b0, waitreq, irq, wake, bnd, ret, push, pop, pcl;
  logic vv;
  logic [7:0] addr = 8'h00, pev = 8'h00, rbyte, v;
  logic [3:0] be = 4'hF, pend;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  vic_addr_t rpc, stop, paddr, pcaddr, pushed, v16, vaddr;
  vic_addr_t loads[$];
  vic_addr_t vecs[$];
  int num_errors = 0, cmp_count = 0, cyc = 0, i, k, r;
  int depth = 0;
  vic_core vic_core_inst (.clk(clk), .reset(reset), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(waitreq), .ext_irq_pin(pin), .timer0_clock_pin(ckp),
    .timer0_overflow(ovf), .periph_events(pev), .instr_boundary(bnd),
    .return_from_irq_instr(ret), .return_pc(rpc), .stack_top(stop), .vector_valid(vv),
    .vector_addr(vaddr), .stack_push(push), .stack_push_addr(paddr), .stack_pop(pop),
    .pc_load(pcl), .pc_load_addr(pcaddr), .wake(wake), .irq(irq));
  vic_cpu_model vic_cpu_model_inst (.clk(clk), .reset(reset), .slow(slow), .ret_req(ret_req),
    .stack_push(push), .stack_push_addr(paddr), .stack_pop(pop), .pc_load(pcl),
    .pc_load_addr(pcaddr), .instr_boundary(bnd), .return_from_irq_instr(ret),
    .return_pc(rpc), .stack_top(stop));
  ////////////////////////////////////////////////////////////////////////////
  // Clock, load monitor and hang guard
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (pcl === 1'b1) loads.push_back(pcaddr);
    if (vv === 1'b1) vecs.push_back(vaddr);
    if (push === 1'b1) pushed <= paddr;
    if (push === 1'b1) depth++;
    if (pop === 1'b1) depth--;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] e);
    cmp_count++;
    if (got !== e) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, e);
    end
  endtask : chk
  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
    @(posedge clk);
    addr <= {idx, 2'b00};
    wdata <= {24'h00_0000, d};
    rd <= ~w;
    wr <= w;
    @(posedge clk iff waitreq === 1'b0);
    rbyte = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic wrr(input logic [5:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask : wrr
  task automatic rdc(input logic [5:0] idx, input logic [7:0] e, input logic [7:0] m);
    bus(1'b0, idx, 8'h00);
    chk({8'h00, rbyte & m}, {8'h00, e & m});
  endtask : rdc
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask : settle
  // Lowest pending index wins: pin, overflow, clock pin, peripherals
  function automatic vic_addr_t exp_vec(input logic [3:0] p);
    if (p[0]) return 16'h0008;
    if (p[1]) return 16'h0010;
    if (p[2]) return 16'h0018;
    return 16'h0020;
  endfunction : exp_vec
  task automatic await_load(input vic_addr_t e);
    int n;
    n = 0;
    while (loads.size() == 0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk(loads.size() > 0 ? loads.pop_front() : 16'hFFFF, e);
  endtask : await_load
  // Return instruction, then the popped address must be reloaded
  task automatic do_return();
    v16 = pushed;
    @(posedge clk);
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    await_load(v16);
  endtask : do_return
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(61));
    settle(8);
    reset <= 1'b0;
    rdc(6'h06, 8'h10, 8'h10);
    rdc(6'h17, 8'h00, 8'hFF);
    rdc(6'h3F, 8'h00, 8'hFF);
    for (i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wrr(6'h17, v);
      rdc(6'h17, v, 8'hFF);
    end
    be <= 4'h0;
    wrr(6'h17, ~v);
    be <= 4'hF;
    rdc(6'h17, v, 8'hFF);
    // Pin edge select, flag, mask and wake with global disable still set
    for (i = 0; i < 2; i++) begin
      wrr(6'h05, i ? 8'h80 : 8'h00);
      pin <= ~i[0];
      settle(6);
      wrr(6'h07, 8'h01);
      pin <= i[0];
      settle(6);
      rdc(6'h07, 8'h10, 8'h10);
      chk({15'h0000, wake}, 16'h0001);
      wrr(6'h07, 8'h10);
      settle(2);
      chk({15'h0000, wake}, 16'h0000);
      wrr(6'h07, 8'h01);
      pin <= ~i[0];
      settle(6);
      rdc(6'h07, 8'h00, 8'h10);
    end
    pin <= 1'b0;
    // Peripheral flag without enables, then group and own enable
    wrr(6'h17, 8'h00);
    wrr(6'h07, 8'h00);
    wrr(6'h06, 8'h00);
    k = $urandom_range(7);
    pev <= 8'h01 << k;
    @(posedge clk);
    pev <= 8'h00;
    rdc(6'h16, 8'h01 << k, 8'hFF);
    rdc(6'h07, 8'h00, 8'h80);
    settle(12);
    chk(16'(loads.size()), 16'h0000);
    wrr(6'h07, 8'h08);
    settle(12);
    chk(16'(loads.size()), 16'h0000);
    wrr(6'h07, 8'h00);
    wrr(6'h17, 8'h01 << k);
    rdc(6'h07, 8'h80, 8'h80);
    settle(12);
    chk(16'(loads.size()), 16'h0000);
    wrr(6'h07, 8'h08);
    await_load(16'h0020);
    chk(vecs.size() > 0 ? vecs.pop_front() : 16'hFFFF, 16'h0020);
    chk(16'(depth), 16'h0001);
    rdc(6'h07, 8'h80, 8'h80);
    rdc(6'h06, 8'h10, 8'h10);
    wrr(6'h16, 8'h00);
    do_return();
    rdc(6'h06, 8'h00, 8'h10);
    // Simultaneous sources serviced in priority order, fast and slow core
    wrr(6'h05, 8'hC0);
    for (r = 0; r < 3; r++) begin
      pend = (r == 0) ? 4'hF : 4'($urandom_range(15, 1));
      slow <= r[0];
      wrr(6'h06, 8'h10);
      wrr(6'h07, 8'h0F);
      wrr(6'h17, 8'hFF);
      k = $urandom_range(7);
      pin <= pend[0];
      ckp <= pend[2];
      ovf <= pend[1];
      pev <= {7'h00, pend[3]} << k;
      @(posedge clk);
      ovf <= 1'b0;
      pev <= 8'h00;
      settle(6);
      pin <= 1'b0;
      ckp <= 1'b0;
      settle(6);
      chk(16'(loads.size()), 16'h0000);
      wrr(6'h06, 8'h00);
      while (pend != 4'h0) begin
        v16 = exp_vec(pend);
        await_load(v16);
        chk(vecs.size() > 0 ? vecs.pop_front() : 16'hFFFF, v16);
        pend = pend & (pend - 4'h1);
        wrr(6'h07, {1'b0, pend[2:0], 4'hF});
        if (!pend[3]) wrr(6'h16, 8'h00);
        do_return();
      end
    end
    // Event status, mask and level output
    rdc(6'h20, 8'h03, 8'h03);
    wrr(6'h21, 8'h01);
    settle(2);
    chk({15'h0000, irq}, 16'h0001);
    wrr(6'h20, 8'h01);
    settle(2);
    chk({15'h0000, irq}, 16'h0000);
    rdc(6'h20, 8'h02, 8'h03);
    chk(16'(depth), 16'h0000);
    give_verdict();
  end
endmodule : testbench
